// ---- bfp_delay_cnt.sv ----
`default_nettype none
module bfp_delay_cnt
	import bfp_pkg::*;
(
	input  wire logic             i_clk,
	input  wire logic             i_srst,
	input  wire logic             i_run,
	input  wire logic [CNT_W-1:0] i_limit,
	output logic                  o_done
);
	logic [CNT_W-1:0] cnt_reg;

	// Dropping i_run restarts the count, so a condition that clears early never accumulates.
	always_ff @(posedge i_clk) begin
		if (i_srst || !i_run || o_done) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_done <= 1'b0;
		end else begin
			o_done <= i_run && !o_done && (cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1} >= i_limit);
		end
	end
endmodule
`default_nettype wire

// ---- bfp_fault_arbiter.sv ----
// Contract
// - An over-discharge detection that begins while over-charge is being detected is held off.
// - An over-charge condition arising during over-discharge detection interrupts that detection.
// - Once over-charge is established, a still-present over-discharge condition is detected again.
// - Over-discharge entered on top of over-charge keeps the part awake and pulls V- up through 200k.
// - With over-charge established first, the V- bias is released to neither supply.
// - Over-charge detection keeps running even when over-current was established earlier.
// - Over-current detection is aborted while over-charge is established.
// - Over-current established first pulls V- to the negative supply through 30k.
// - Over-discharge detection keeps running even when over-current was established earlier.
// - Over-current detection is aborted while over-discharge is established.
// - Over-discharge after over-current swaps V- from the 30k pull-down to the 200k pull-up and enters standby.
// - Short-circuit detection runs regardless of every other detection state.
// - Excessive-charger detection is inhibited during over-discharge, over-current and short-circuit.
// - The excessive-charger delay starts only after the discharge gate is back high.
// - After its delay over-discharge turns the discharge gate low and then enters standby.
// - The shorten input cuts every counter delay except the short-circuit delay.
`default_nettype none
module bfp_fault_arbiter
	import bfp_pkg::*;
#(
	parameter int OCHG_DET = OCHG_DET_CYC,
	parameter int OCHG_REL = OCHG_REL_CYC,
	parameter int ODIS_DET = ODIS_DET_CYC,
	parameter int ODIS_REL = ODIS_REL_CYC,
	parameter int OCUR_DET = OCUR_DET_CYC,
	parameter int OCUR_REL = OCUR_REL_CYC,
	parameter int SHORT_DET = SHORT_DET_CYC,
	parameter int XCHG_DET = XCHG_DET_CYC,
	parameter int XCHG_REL = XCHG_REL_CYC
)(
	input  wire logic i_clk,
	input  wire logic i_srst,
	input  wire logic i_ochg_cond,
	input  wire logic i_odis_cond,
	input  wire logic i_ocur_cond,
	input  wire logic i_short_cond,
	input  wire logic i_xchg_cond,
	input  wire logic i_shorten,
	output logic      o_chg_gate,
	output logic      o_dis_gate,
	output logic      o_vm_pull_up,
	output logic      o_vm_pull_down,
	output logic      o_standby
);
	logic ochg_reg;
	logic odis_reg;
	logic ocur_reg;
	logic short_reg;
	logic xchg_reg;
	logic ochg_det;
	logic odis_run;
	logic ocur_run;
	logic short_run;
	logic xchg_run;
	logic ochg_run;
	logic [CNT_W-1:0] ocur_age_reg;
	logic ochg_done;
	logic odis_done;
	logic ocur_done;
	logic short_done;
	logic xchg_done;

	function automatic logic [CNT_W-1:0] pick(input int det, input int rel, input logic releasing,
	                                          input logic cut);
		int base;
		base = releasing ? rel : det;
		if (cut) begin
			base = base / SHORTEN_DIV;
		end
		if (base < 1) begin
			base = 1;
		end
		return base[CNT_W-1:0];
	endfunction

	assign ochg_det  = i_ochg_cond && !ochg_reg;
	// Over-charge runs whatever the over-current state is.
	assign xchg_run  = (i_xchg_cond != xchg_reg) && !odis_reg && !ocur_reg && !short_reg && o_dis_gate;
	assign short_run = i_short_cond != short_reg;
	assign odis_run  = (i_odis_cond != odis_reg) && !ochg_det;
	assign ocur_run  = (i_ocur_cond != ocur_reg) && !ochg_reg && !odis_reg;
	assign ochg_run  = i_ochg_cond != ochg_reg;

	bfp_delay_cnt u_ochg (.i_clk(i_clk), .i_srst(i_srst), .i_run(ochg_run),
		.i_limit(pick(OCHG_DET, OCHG_REL, ochg_reg, i_shorten)), .o_done(ochg_done));
	bfp_delay_cnt u_odis (.i_clk(i_clk), .i_srst(i_srst), .i_run(odis_run),
		.i_limit(pick(ODIS_DET, ODIS_REL, odis_reg, i_shorten)), .o_done(odis_done));
	bfp_delay_cnt u_ocur (.i_clk(i_clk), .i_srst(i_srst), .i_run(ocur_run),
		.i_limit(pick(OCUR_DET, OCUR_REL, ocur_reg, i_shorten)), .o_done(ocur_done));
	// The short-circuit delay is fixed on purpose; the shorten pin must not touch it.
	bfp_delay_cnt u_short (.i_clk(i_clk), .i_srst(i_srst), .i_run(short_run),
		.i_limit(pick(SHORT_DET, OCUR_REL, short_reg, 1'b0)), .o_done(short_done));
	bfp_delay_cnt u_xchg (.i_clk(i_clk), .i_srst(i_srst), .i_run(xchg_run),
		.i_limit(pick(XCHG_DET, XCHG_REL, xchg_reg, i_shorten)), .o_done(xchg_done));

	// A done pulse is only honoured while its run term still holds, so an abort in the same cycle wins.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ochg_reg <= RST_FLAG;
		end else if (ochg_done && ochg_run) begin
			ochg_reg <= !ochg_reg;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			odis_reg <= RST_FLAG;
		end else if (odis_done && odis_run) begin
			odis_reg <= !odis_reg;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ocur_reg <= RST_FLAG;
		end else if (ocur_done && ocur_run) begin
			ocur_reg <= !ocur_reg;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			short_reg <= RST_FLAG;
		end else if (short_done && short_run) begin
			short_reg <= !short_reg;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			xchg_reg <= RST_FLAG;
		end else if (xchg_done && xchg_run) begin
			xchg_reg <= !xchg_reg;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_chg_gate <= RST_GATE_ON;
			o_dis_gate <= RST_GATE_ON;
		end else begin
			o_chg_gate <= !(ochg_reg || xchg_reg);
			o_dis_gate <= !(odis_reg || ocur_reg || short_reg);
		end
	end

	// Over-discharge owns V- whenever it is established, which also covers the swap away from 30k.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_vm_pull_up   <= 1'b0;
			o_vm_pull_down <= 1'b0;
		end else begin
			o_vm_pull_up   <= odis_reg;
			o_vm_pull_down <= !odis_reg && (ocur_reg || short_reg);
		end
	end

	// Standby follows the gate by one cycle, so the switch is already off when the part sleeps.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_standby <= 1'b0;
		end else begin
			o_standby <= odis_reg && !o_dis_gate && !ochg_reg;
		end
	end

	// Unbroken run length of the over-current count, kept apart from the shared counter.
	// Only the assertions read it, so a counter that fails to restart cannot hide behind its own state.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ocur_age_reg <= '0;
		end else if (ocur_run) begin
			ocur_age_reg <= ocur_age_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end else begin
			ocur_age_reg <= '0;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	odis_hold_a: assert property ($rose(odis_reg) |-> !$past(ochg_det))
		else $error("over-discharge established during over-charge detection");
	odis_resume_a: assert property (ochg_reg && i_odis_cond && !odis_reg |-> odis_run)
		else $error("over-discharge detection not resumed");
	ocur_abort_a: assert property ($rose(ocur_reg) |-> !$past(ochg_reg) && !$past(odis_reg))
		else $error("over-current established after over-charge or over-discharge");
	awake_a: assert property (ochg_reg |=> !o_standby)
		else $error("standby entered with over-charge established");
	pull_up_a: assert property (odis_reg |=> o_vm_pull_up && !o_vm_pull_down)
		else $error("V- not pulled up during over-discharge");
	pull_down_a: assert property (!odis_reg && ocur_reg |=> o_vm_pull_down && !o_vm_pull_up)
		else $error("V- not pulled down during over-current");
	release_a: assert property (ochg_reg && !odis_reg && !ocur_reg && !short_reg |=>
		!o_vm_pull_up && !o_vm_pull_down)
		else $error("V- not released under over-charge");
	sleep_seq_a: assert property ($rose(odis_reg) && !ochg_reg |=> !o_dis_gate ##1 (o_standby || ochg_reg))
		else $error("gate low then standby sequence broken");
	xchg_gate_a: assert property ($rose(xchg_reg) |-> $past(o_dis_gate))
		else $error("excessive charger detected with discharge gate low");
	short_free_a: assert property ($rose(short_reg) |-> $past(i_short_cond))
		else $error("short circuit set without its condition");
	restart_a: assert property (!ochg_run |=> !ochg_done)
		else $error("over-charge delay done after condition cleared");
	ocur_delay_a: assert property ($rose(ocur_reg) && !$past(i_shorten) |->
		$past(ocur_age_reg) >= OCUR_DET[CNT_W-1:0])
		else $error("over-current established before its full unbroken delay");
	pull_excl_a: assert property (!(o_vm_pull_up && o_vm_pull_down))
		else $error("V- pulled to both supplies at once");
	short_gate_a: assert property (short_reg |=> !o_dis_gate)
		else $error("discharge gate on during short circuit");
	odis_gate_a: assert property (odis_reg |=> !o_dis_gate)
		else $error("discharge gate on during over-discharge");

	ochg_c: cover property ($rose(ochg_reg));
	odis_after_ochg_c: cover property (ochg_reg && $rose(odis_reg));
	ocur_to_odis_c: cover property (ocur_reg && $rose(odis_reg));
	xchg_c: cover property ($rose(xchg_reg));
	short_c: cover property ($rose(short_reg));
endmodule
`default_nettype wire

// ---- bfp_fault_arbiter_test.sv ----
`default_nettype none
module bfp_fault_arbiter_test
	import bfp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int OCHG = 12;
	localparam int ODIS = 6;
	localparam int OCUR = 6;
	localparam int SHRT = 5;
	localparam int XCHG = 8;
	localparam int REL  = 8;
	logic clk = 1'b0, srst = 1'b1, ochg = 1'b0, odis = 1'b0, ocur = 1'b0, shrt = 1'b0, xchg = 1'b0, shorten = 1'b0;
	logic chg, dis, pu, pd, sb, chg_path, dis_path;
	int   bad_count = 0;
	int   checked   = 0;
	int   cycles    = 0;
	bfp_fault_arbiter #(.OCHG_DET(OCHG), .OCHG_REL(REL), .ODIS_DET(ODIS), .ODIS_REL(REL), .OCUR_DET(OCUR),
		.OCUR_REL(REL), .SHORT_DET(SHRT), .XCHG_DET(XCHG), .XCHG_REL(REL)) bfp_fault_arbiter_inst (
		.i_clk(clk), .i_srst(srst), .i_ochg_cond(ochg), .i_odis_cond(odis), .i_ocur_cond(ocur),
		.i_short_cond(shrt), .i_xchg_cond(xchg), .i_shorten(shorten), .o_chg_gate(chg), .o_dis_gate(dis),
		.o_vm_pull_up(pu), .o_vm_pull_down(pd), .o_standby(sb));
	bfp_fet_model bfp_fet_model_inst (.i_chg_gate(chg), .i_dis_gate(dis), .o_chg_path(chg_path),
		.o_dis_path(dis_path));
	initial begin
		forever #2.5 clk = ~clk;
	end
	// The whole sequence needs well under a thousand cycles; the ceiling only catches a hang.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			bad_count = bad_count + 1;
			results();
		end
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string name, input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", name, exp, got);
		end
	endtask
	// Expected order is charge gate, discharge gate, pull-up, pull-down, standby; x skips a bit.
	task automatic outs(input logic [4:0] exp);
		string nm[5] = '{"standby", "pull_down", "pull_up", "dis_gate", "chg_gate"};
		logic [4:0] got;
		got = {chg, dis, pu, pd, sb};
		for (int i = 0; i < 5; i++) begin
			if (exp[i] !== 1'bx) chk(nm[i], got[i], exp[i]);
		end
	endtask
	task automatic rst();
		@(posedge clk) {ochg, odis, ocur, shrt, xchg, shorten, srst} <= 7'h01;
		@(posedge clk) srst <= 1'b0;
		wt(2);
	endtask
	task automatic s_ocur_odis();
		rst();
		@(posedge clk) ocur <= 1'b1;
		wt(OCUR + 5);
		outs(5'b10010);
		chk("dis_path", dis_path, 1'b0);
		@(posedge clk) odis <= 1'b1;
		wt(ODIS + 6);
		outs(5'b10101);
	endtask
	task automatic s_ochg_odis();
		rst();
		@(posedge clk) ochg <= 1'b1;
		wt(1);
		@(posedge clk) odis <= 1'b1;
		wt(OCHG + 3);
		outs(5'b01000);
		wt(ODIS + 6);
		outs(5'b00100);
	endtask
	task automatic s_odis_ochg();
		rst();
		@(posedge clk) odis <= 1'b1;
		wt(1);
		@(posedge clk) ochg <= 1'b1;
		wt(ODIS + 2);
		outs(5'b11000);
		wt(OCHG + ODIS + 8);
		outs(5'b00100);
	endtask
	task automatic s_ocur_ochg();
		rst();
		@(posedge clk) ocur <= 1'b1;
		wt(OCUR + 5);
		@(posedge clk) ochg <= 1'b1;
		wt(OCHG + 5);
		outs(5'b00010);
		chk("chg_path", chg_path, 1'b0);
	endtask
	task automatic s_ochg_ocur();
		rst();
		@(posedge clk) ochg <= 1'b1;
		wt(OCHG + 5);
		@(posedge clk) ocur <= 1'b1;
		wt(OCUR + 6);
		outs(5'b01000);
	endtask
	task automatic s_odis_xchg();
		rst();
		@(posedge clk) odis <= 1'b1;
		wt(ODIS + 6);
		outs(5'b10101);
		@(posedge clk) {ocur, xchg} <= 2'h3;
		wt(XCHG + 6);
		outs(5'b10101);
		@(posedge clk) {odis, ocur} <= 2'h0;
		for (int i = 0; i < 40 && dis !== 1'b1; i++) wt(1);
		chk("dis_gate", dis, 1'b1);
		wt(XCHG + 1);
		chk("chg_gate", chg, 1'b1);
		wt(1);
		chk("chg_gate", chg, 1'b0);
	endtask
	task automatic s_short();
		rst();
		@(posedge clk) {shorten, ochg} <= 2'h3;
		wt(6);
		chk("chg_gate", chg, 1'b0);
		@(posedge clk) shrt <= 1'b1;
		wt(3);
		chk("dis_gate", dis, 1'b1);
		wt(6);
		chk("dis_gate", dis, 1'b0);
	endtask
	task automatic s_restart();
		rst();
		@(posedge clk) ocur <= 1'b1;
		wt(3);
		@(posedge clk) ocur <= 1'b0;
		@(posedge clk) ocur <= 1'b1;
		wt(OCUR + 1);
		chk("dis_gate", dis, 1'b1);
		wt(4);
		chk("dis_gate", dis, 1'b0);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		wt(2);
		outs(5'b11000);
		s_ocur_odis();
		s_ochg_odis();
		s_odis_ochg();
		s_ocur_ochg();
		s_ochg_ocur();
		s_odis_xchg();
		s_short();
		s_restart();
		results();
	end
endmodule
`default_nettype wire

// ---- bfp_fet_model.sv ----
`default_nettype none
// Ideal N-channel switches; the body diode path is left out, so a low gate fully blocks.
module bfp_fet_model (
	input  wire logic i_chg_gate,
	input  wire logic i_dis_gate,
	output logic      o_chg_path,
	output logic      o_dis_path
);
	timeunit 1ns;
	timeprecision 100ps;
	assign o_chg_path = i_chg_gate;
	assign o_dis_path = i_dis_gate;
endmodule
`default_nettype wire

// ---- bfp_pkg.sv ----
`default_nettype none
package bfp_pkg;
	localparam int CLK_MHZ         = 200;
	localparam int CNT_W           = 32;
	// Delay figures in microseconds; the counts below are cycles at CLK_MHZ.
	localparam int T_OCHG_DET_US   = 1000;
	localparam int T_OCHG_REL_US   = 1000;
	localparam int T_ODIS_DET_US   = 1000;
	localparam int T_ODIS_REL_US   = 1000;
	localparam int T_OCUR_DET_US   = 100;
	localparam int T_OCUR_REL_US   = 100;
	localparam int T_SHORT_DET_US  = 1;
	localparam int T_XCHG_DET_US   = 1000;
	localparam int T_XCHG_REL_US   = 1000;
	localparam int OCHG_DET_CYC    = T_OCHG_DET_US * CLK_MHZ;
	localparam int OCHG_REL_CYC    = T_OCHG_REL_US * CLK_MHZ;
	localparam int ODIS_DET_CYC    = T_ODIS_DET_US * CLK_MHZ;
	localparam int ODIS_REL_CYC    = T_ODIS_REL_US * CLK_MHZ;
	localparam int OCUR_DET_CYC    = T_OCUR_DET_US * CLK_MHZ;
	localparam int OCUR_REL_CYC    = T_OCUR_REL_US * CLK_MHZ;
	localparam int SHORT_DET_CYC   = T_SHORT_DET_US * CLK_MHZ;
	localparam int XCHG_DET_CYC    = T_XCHG_DET_US * CLK_MHZ;
	localparam int XCHG_REL_CYC    = T_XCHG_REL_US * CLK_MHZ;
	localparam int SHORTEN_DIV     = 64;
	localparam logic RST_GATE_ON   = 1'b1;
	localparam logic RST_FLAG      = 1'b0;
endpackage
`default_nettype wire
